// *** ahs_pkg.sv ***
// Shared constants and types for the axis homing and status logic
package ahs_pkg;
  // Geometry
  localparam int NUM_AXES = 3;
  localparam int LANES_PER_AXIS = 4;
  localparam int SPEED_W = 16;
  // Command byte classes in bits 7:6
  localparam logic [1:0] CLS_STOP = 2'h0;
  localparam logic [1:0] CLS_HOME = 2'h1;
  localparam logic [1:0] CLS_REG_SEL = 2'h2;
  localparam logic [1:0] CLS_OUT_MODE = 2'h3;
  localparam int CLS_MSB = 7;
  localparam int CLS_LSB = 6;
  localparam int MON_EXT_BIT = 5;
  localparam logic [7:0] REG_SEL_MASK = 8'h07;
  // Register selector codes
  localparam logic [2:0] SEL_CUR_SPEED = 3'h6;
  localparam logic [2:0] SEL_EXT_STATUS = 3'h7;
  // Home mode codes
  localparam logic [3:0] HOME_MODE0 = 4'h0;
  localparam logic [3:0] HOME_MODE1 = 4'h1;
  localparam logic [3:0] HOME_MODE6 = 4'h6;
  localparam logic [3:0] HOME_MODE9 = 4'h9;
  // Second status byte fields
  localparam int ST1_NEG_LIMIT_BIT = 0;
  localparam int ST1_POS_LIMIT_BIT = 1;
  // Reset values
  localparam logic MON_EXT_RESET = 1'b0;
  localparam logic [2:0] REG_SEL_RESET = 3'h0;
  localparam logic DIR_RESET = 1'b1;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_ESCAPE, ST_DECEL, ST_BACK, ST_APPROACH
  } ahs_state_t;
endpackage

// *** ahs_pulse_if.sv ***
// Link between the sequencer and one step pulse engine
`timescale 1ns/100ps
interface ahs_pulse_if;
  logic run;
  logic restart;
  logic ramp_up;
  logic dir;
  logic [15:0] start_period;
  logic [15:0] max_period;
  logic step;
  logic step_dir;
  logic at_start;
  logic [15:0] period;
  modport seq (
    output run, restart, ramp_up, dir, start_period, max_period,
    input step, step_dir, at_start, period
  );
  modport engine (
    input run, restart, ramp_up, dir, start_period, max_period,
    output step, step_dir, at_start, period
  );
endinterface

// *** ahs_pulse_engine.sv ***
// Step pulse engine with linear period ramp between two speeds
`timescale 1ns/100ps
module ahs_pulse_engine (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Sequencer side
  ahs_pulse_if.engine pif
);
  logic [15:0] cnt;
  logic [15:0] next_period;

  // Ramp one period unit per step toward the target speed
  always_comb
  begin
    if (pif.ramp_up)
      next_period = (pif.period > pif.max_period) ?
                    pif.period - 16'h0001 : pif.max_period;
    else
      next_period = (pif.period < pif.start_period) ?
                    pif.period + 16'h0001 : pif.start_period;
  end

  // Period countdown and step pulse
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !pif.run || pif.restart)
    begin
      pif.period <= pif.start_period;
      cnt <= pif.start_period;
      pif.step <= 1'b0;
    end
    else if (cnt <= 16'h0001)
    begin
      pif.step <= 1'b1;
      cnt <= next_period;
      pif.period <= next_period;
    end
    else
    begin
      pif.step <= 1'b0;
      cnt <= cnt - 16'h0001;
    end
  end

  // Direction follows the sequencer one cycle later
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      pif.step_dir <= ahs_pkg::DIR_RESET;
    else
      pif.step_dir <= pif.dir;
  end

  assign pif.at_start = (pif.period >= pif.start_period);
endmodule // ahs_pulse_engine

// *** ahs_axis_home_status.sv ***
// Three-axis homing sequencer with monitor status lanes
// Behaviour
// - Standard monitor shows status bytes 0-1, extended shows bytes 0-3.
// - Bit 5 of the output mode command picks the monitor mode.
// - The end-limit state sits in the second status byte in either mode.
// - The register select command takes its selector from bits 2:0.
// - Axis n owns status lanes 4n to 4n+3 for three axes.
// - Second status byte bit 0 is negative limit, bit 1 positive limit.
// - Only home modes 0, 1, 6 and 9 are accepted.
// - Home, limit and index are high-active; a rising edge is a trigger.
// - Homing runs only at start speed, max speed and ramps between.
// - Mode 0 ramps up, decelerates at home, stops at start speed.
// - Mode 1 then reverses and re-approaches home at start speed.
// - Mode 6 ramps toward the limit and stops at once on reaching it.
// - Mode 9 decelerates at home, backs off slowly, stops on leaving it.
// - In modes 0, 1, 9 a limit first reverses, crosses home, seeks again.
// - Each origin and limit input is normally closed when its bit is 1.
`timescale 1ns/100ps
module ahs_axis_home_status (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Command buffer
  input wire logic cmd_wr_in,
  input wire logic [1:0] cmd_axis_in,
  input wire logic [7:0] cmd_data_in,
  // Status lane read
  input wire logic [3:0] rd_lane_in,
  output logic [7:0] rd_data_out,
  // Speed settings, as step periods in clock cycles
  input wire logic [2:0][15:0] start_speed_in,
  input wire logic [2:0][15:0] max_speed_in,
  // Sensor pins and contact type, bit 0 origin, 1 pos, 2 neg
  input wire logic [2:0] home_pin_in,
  input wire logic [2:0] positive_end_limit_in,
  input wire logic [2:0] negative_end_limit_in,
  input wire logic [2:0] encoder_index_pulse_in,
  input wire logic [2:0][2:0] contact_nc_in,
  // Motor driver and completion
  output logic [2:0] step_out,
  output logic [2:0] dir_out,
  output logic [2:0] home_done_out
);
  // Per-axis state
  ahs_pkg::ahs_state_t state [3];
  logic [3:0] sync1 [3];
  logic [3:0] sync2 [3];
  logic [2:0] home_prev;
  logic [2:0] home_lvl;
  logic [2:0] pos_lvl;
  logic [2:0] neg_lvl;
  logic [2:0] idx_lvl;
  logic [2:0] home_rise;
  logic [2:0] lim_ahead;
  logic [2:0] mon_ext;
  logic [2:0][2:0] reg_sel;
  logic [2:0][3:0] mode;
  logic [2:0] dir;
  logic [2:0] restart;
  logic [2:0] done;
  logic [2:0] lim_stop;
  logic [2:0] seen_home;
  logic [2:0][15:0] period;
  logic [2:0] at_start;

  // True for the four supported home modes
  function automatic logic mode_ok(input logic [3:0] m);
    mode_ok = (m == ahs_pkg::HOME_MODE0) || (m == ahs_pkg::HOME_MODE1) ||
              (m == ahs_pkg::HOME_MODE6) || (m == ahs_pkg::HOME_MODE9);
  endfunction

  // Byte shown on one lane of one axis
  function automatic logic [7:0] lane_byte(
    input logic [1:0] lane, input logic ext, input logic [2:0] sel,
    input logic busy, input logic dn, input logic ls, input logic ix,
    input logic hm, input logic dr, input logic pl, input logic nl,
    input logic [3:0] md, input logic [15:0] per);
    logic [7:0] b;
    b = 8'h00;
    case (lane)
      2'h0: b = {busy, dn, ls, 2'h0, ix, hm, dr};
      2'h1:
      begin
        b[ahs_pkg::ST1_NEG_LIMIT_BIT] = nl;
        b[ahs_pkg::ST1_POS_LIMIT_BIT] = pl;
        b[2] = hm;
      end
      2'h2:
      begin
        if (ext && sel == ahs_pkg::SEL_CUR_SPEED)
          b = per[7:0];
        else if (ext && sel == ahs_pkg::SEL_EXT_STATUS)
          b = {md, 1'b0, sel};
      end
      2'h3:
      begin
        if (ext && sel == ahs_pkg::SEL_CUR_SPEED)
          b = per[15:8];
      end
      default: b = 8'h00;
    endcase
    lane_byte = b;
  endfunction

  genvar a;
  generate
    for (a = 0; a < ahs_pkg::NUM_AXES; a++)
    begin : g_axis
      ahs_pulse_if pif();
      logic cmd_hit;
      logic [1:0] cls;

      assign cmd_hit = cmd_wr_in && (cmd_axis_in == 2'(a));
      assign cls = cmd_data_in[ahs_pkg::CLS_MSB:ahs_pkg::CLS_LSB];

      // Two-flop synchronisers for sensor pins
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_n_in)
        begin
          sync1[a] <= 4'h0;
          sync2[a] <= 4'h0;
        end
        else
        begin
          sync1[a] <= {encoder_index_pulse_in[a], negative_end_limit_in[a],
                       positive_end_limit_in[a], home_pin_in[a]};
          sync2[a] <= sync1[a];
        end
      end

      // Contact type and active-high levels
      assign home_lvl[a] = sync2[a][0] ^ contact_nc_in[a][0];
      assign pos_lvl[a] = sync2[a][1] ^ contact_nc_in[a][1];
      assign neg_lvl[a] = sync2[a][2] ^ contact_nc_in[a][2];
      assign idx_lvl[a] = sync2[a][3];
      assign home_rise[a] = home_lvl[a] && !home_prev[a];
      assign lim_ahead[a] = dir[a] ? pos_lvl[a] : neg_lvl[a];

      // Home edge detector, reset high so no false edge follows reset
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_n_in)
          home_prev[a] <= 1'b1;
        else
          home_prev[a] <= home_lvl[a];
      end

      // Monitor mode and register selector
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_n_in)
        begin
          mon_ext[a] <= ahs_pkg::MON_EXT_RESET;
          reg_sel[a] <= ahs_pkg::REG_SEL_RESET;
        end
        else if (cmd_hit && cls == ahs_pkg::CLS_OUT_MODE)
          mon_ext[a] <= cmd_data_in[ahs_pkg::MON_EXT_BIT];
        else if (cmd_hit && cls == ahs_pkg::CLS_REG_SEL)
          reg_sel[a] <= 3'(cmd_data_in & ahs_pkg::REG_SEL_MASK);
      end

      // Homing sequencer
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_n_in)
        begin
          state[a] <= ahs_pkg::ST_IDLE;
          mode[a] <= ahs_pkg::HOME_MODE0;
          dir[a] <= ahs_pkg::DIR_RESET;
          restart[a] <= 1'b0;
          done[a] <= 1'b0;
          lim_stop[a] <= 1'b0;
          seen_home[a] <= 1'b0;
        end
        else
        begin
          restart[a] <= 1'b0;
          if (cmd_hit && cls == ahs_pkg::CLS_STOP)
            state[a] <= ahs_pkg::ST_IDLE;
          else
          begin
            case (state[a])
              ahs_pkg::ST_IDLE:
              begin
                if (cmd_hit && cls == ahs_pkg::CLS_HOME &&
                    mode_ok(cmd_data_in[3:0]))
                begin
                  mode[a] <= cmd_data_in[3:0];
                  dir[a] <= ahs_pkg::DIR_RESET;
                  done[a] <= 1'b0;
                  lim_stop[a] <= 1'b0;
                  seen_home[a] <= 1'b0;
                  state[a] <= ahs_pkg::ST_SEEK;
                end
              end
              ahs_pkg::ST_SEEK:
              begin
                if (mode[a] == ahs_pkg::HOME_MODE6)
                begin
                  if (lim_ahead[a])
                  begin
                    done[a] <= 1'b1;
                    lim_stop[a] <= 1'b1;
                    state[a] <= ahs_pkg::ST_IDLE;
                  end
                end
                else if (home_rise[a])
                  state[a] <= ahs_pkg::ST_DECEL;
                else if (lim_ahead[a])
                begin
                  dir[a] <= !dir[a];
                  restart[a] <= 1'b1;
                  seen_home[a] <= 1'b0;
                  state[a] <= ahs_pkg::ST_ESCAPE;
                end
              end
              ahs_pkg::ST_ESCAPE:
              begin
                if (home_lvl[a])
                  seen_home[a] <= 1'b1;
                if (lim_ahead[a])
                begin
                  lim_stop[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_IDLE;
                end
                else if (seen_home[a] && !home_lvl[a])
                begin
                  dir[a] <= !dir[a];
                  restart[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_SEEK;
                end
              end
              ahs_pkg::ST_DECEL:
              begin
                if (lim_ahead[a])
                begin
                  lim_stop[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_IDLE;
                end
                else if (at_start[a] && mode[a] == ahs_pkg::HOME_MODE0)
                begin
                  done[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_IDLE;
                end
                else if (at_start[a])
                begin
                  dir[a] <= !dir[a];
                  restart[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_BACK;
                end
              end
              ahs_pkg::ST_BACK:
              begin
                if (lim_ahead[a])
                begin
                  lim_stop[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_IDLE;
                end
                else if (!home_lvl[a] && mode[a] == ahs_pkg::HOME_MODE9)
                begin
                  done[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_IDLE;
                end
                else if (!home_lvl[a])
                begin
                  dir[a] <= !dir[a];
                  restart[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_APPROACH;
                end
              end
              ahs_pkg::ST_APPROACH:
              begin
                if (lim_ahead[a])
                begin
                  lim_stop[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_IDLE;
                end
                else if (home_rise[a])
                begin
                  done[a] <= 1'b1;
                  state[a] <= ahs_pkg::ST_IDLE;
                end
              end
              default: state[a] <= ahs_pkg::ST_IDLE;
            endcase
          end
        end
      end

      // Pulse engine: ramp up while seeking; a limit ahead halts it at once
      assign pif.run = (state[a] != ahs_pkg::ST_IDLE) &&
                       !lim_ahead[a];
      assign pif.restart = restart[a];
      assign pif.ramp_up = (state[a] == ahs_pkg::ST_SEEK) ||
                           (state[a] == ahs_pkg::ST_ESCAPE);
      assign pif.dir = dir[a];
      assign pif.start_period = start_speed_in[a];
      assign pif.max_period = max_speed_in[a];
      assign step_out[a] = pif.step;
      assign dir_out[a] = pif.step_dir;
      assign home_done_out[a] = done[a];
      assign period[a] = pif.period;
      assign at_start[a] = pif.at_start;

      ahs_pulse_engine u_engine (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .pif(pif)
      );
    end
  endgenerate

  // Registered lane read, lanes 12-15 read zero
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      rd_data_out <= 8'h00;
    else if (rd_lane_in[3:2] == 2'h3)
      rd_data_out <= 8'h00;
    else
    begin
      rd_data_out <= lane_byte(rd_lane_in[1:0],
        mon_ext[rd_lane_in[3:2]], reg_sel[rd_lane_in[3:2]],
        state[rd_lane_in[3:2]] != ahs_pkg::ST_IDLE,
        done[rd_lane_in[3:2]], lim_stop[rd_lane_in[3:2]],
        idx_lvl[rd_lane_in[3:2]], home_lvl[rd_lane_in[3:2]],
        dir[rd_lane_in[3:2]], pos_lvl[rd_lane_in[3:2]],
        neg_lvl[rd_lane_in[3:2]], mode[rd_lane_in[3:2]],
        period[rd_lane_in[3:2]]);
    end
  end
endmodule // ahs_axis_home_status

// *** ahs_checker_assertions.sv ***
// Port-level assertions for the axis homing and status logic
`timescale 1ns/100ps
module ahs_checker (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Command buffer and status read
  input wire logic cmd_wr_in,
  input wire logic [1:0] cmd_axis_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic [3:0] rd_lane_in,
  input wire logic [7:0] rd_data_out,
  // Speeds, sensors and contact type
  input wire logic [2:0][15:0] start_speed_in,
  input wire logic [2:0][15:0] max_speed_in,
  input wire logic [2:0] home_pin_in,
  input wire logic [2:0] positive_end_limit_in,
  input wire logic [2:0] negative_end_limit_in,
  input wire logic [2:0] encoder_index_pulse_in,
  input wire logic [2:0][2:0] contact_nc_in,
  // Motor driver and completion
  input wire logic [2:0] step_out,
  input wire logic [2:0] dir_out,
  input wire logic [2:0] home_done_out
);
  logic [2:0] ext;
  logic [3:0] quiet;
  logic [15:0] gap;
  logic [2:0] pos_act;
  logic [2:0] neg_act;
  logic [1:0] lim_now;
  logic hit;
  logic home_cmd;
  logic good_md;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Decoded command and active sensor levels
  assign hit = cmd_wr_in && (cmd_axis_in == 2'h0);
  assign home_cmd = hit && (cmd_data_in[7:6] == ahs_pkg::CLS_HOME);
  assign good_md = cmd_data_in[3:0] inside {ahs_pkg::HOME_MODE0,
    ahs_pkg::HOME_MODE1, ahs_pkg::HOME_MODE6, ahs_pkg::HOME_MODE9};
  always_comb
    for (int a = 0; a < 3; a++)
    begin
      pos_act[a] = positive_end_limit_in[a] ^ contact_nc_in[a][1];
      neg_act[a] = negative_end_limit_in[a] ^ contact_nc_in[a][2];
    end
  assign lim_now = {pos_act[rd_lane_in[3:2]], neg_act[rd_lane_in[3:2]]};
  // Monitor mode as last written per axis
  always_ff @(posedge clk_sys_in)
    if (!rst_n_in)
      ext <= 3'h0;
    else if (cmd_wr_in && cmd_axis_in != 2'h3 && cmd_data_in[7:6] == 2'h3)
      ext[cmd_axis_in] <= cmd_data_in[ahs_pkg::MON_EXT_BIT];
  // Cycles since any home or limit pin or contact type changed
  always_ff @(posedge clk_sys_in)
    if (!rst_n_in || $changed({home_pin_in, positive_end_limit_in,
        negative_end_limit_in, contact_nc_in}))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  // Cycles between step pulses of axis 0
  always_ff @(posedge clk_sys_in)
    if (!rst_n_in)
      gap <= 16'hffff;
    else if (step_out[0])
      gap <= 16'h1;
    else if (gap != 16'hffff)
      gap <= gap + 16'h1;

  a_reset_values: assert property (disable iff (1'b0) !rst_n_in |=>
    step_out == 3'h0 && home_done_out == 3'h0 && dir_out == 3'h7)
    else $error("outputs not at reset values");
  a_step_not_fast: assert property (step_out[0] |->
    gap >= max_speed_in[0]) else $error("step faster than max speed");
  a_high_lanes_zero: assert property (rd_lane_in >= 4'hc |=>
    rd_data_out == 8'h00) else $error("lane above eleven not zero");
  a_std_lanes_zero: assert property (rd_lane_in < 4'hc && rd_lane_in[1]
    && !ext[rd_lane_in[3:2]] && !cmd_wr_in |=> rd_data_out == 8'h00)
    else $error("extended lane visible in standard monitor");
  a_limit_bits: assert property (quiet >= 4'h4 && rd_lane_in < 4'hc &&
    rd_lane_in[1:0] == 2'h1 |=> rd_data_out[1:0] == $past(lim_now))
    else $error("limit bits of second status byte wrong");
  a_done_no_step: assert property ((home_done_out & step_out) == 3'h0)
    else $error("step while homing done");
  a_start_clears_done: assert property (home_done_out[0] && home_cmd
    && good_md |=> !home_done_out[0]) else $error("start kept done");
  a_bad_mode_kept: assert property (home_done_out[0] && ((home_cmd &&
    !good_md) || (hit && cmd_data_in[7:6] == 2'h0)) |=> home_done_out[0])
    else $error("refused command changed done");
  a_limit_halts: assert property (quiet >= 4'h6 |-> (step_out &
    ((pos_act & dir_out) | (neg_act & ~dir_out))) == 3'h0)
    else $error("step toward an active limit");
  c_all_done: cover property (home_done_out == 3'h7);
  c_ext_read: cover property (ext[0] && rd_lane_in == 4'h2);
  c_nc_done: cover property (contact_nc_in[0] == 3'h7 && home_done_out[0]);
endmodule // ahs_checker

bind ahs_axis_home_status ahs_checker u_checker (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cmd_wr_in(cmd_wr_in),
  .cmd_axis_in(cmd_axis_in), .cmd_data_in(cmd_data_in),
  .rd_lane_in(rd_lane_in), .rd_data_out(rd_data_out),
  .start_speed_in(start_speed_in), .max_speed_in(max_speed_in),
  .home_pin_in(home_pin_in), .positive_end_limit_in(positive_end_limit_in),
  .negative_end_limit_in(negative_end_limit_in),
  .encoder_index_pulse_in(encoder_index_pulse_in),
  .contact_nc_in(contact_nc_in), .step_out(step_out), .dir_out(dir_out),
  .home_done_out(home_done_out));

// *** ahs_motor_model.sv ***
// Behavioural motor with origin sensor, limits and index for three axes
`timescale 1ns/100ps
module ahs_motor_model #(
  parameter int HOME_LO = 40,
  parameter int HOME_HI = 59,
  parameter int LIMIT = 100,
  parameter int INDEX_MOD = 10
) (
  // Clock and position preset
  input wire logic clk_sys_in,
  input wire logic load_in,
  input wire logic [15:0] load_pos_in,
  // Driver and contact type
  input wire logic [2:0] step_in,
  input wire logic [2:0] dir_in,
  input wire logic [2:0][2:0] contact_nc_in,
  // Sensor pins
  output logic [2:0] home_pin_out,
  output logic [2:0] pos_limit_out,
  output logic [2:0] neg_limit_out,
  output logic [2:0] index_out
);
  int pos [3];
  // Position follows the step pulses
  always @(posedge clk_sys_in)
    for (int a = 0; a < 3; a++)
      if (load_in)
        pos[a] <= int'(signed'(load_pos_in));
      else if (step_in[a])
        pos[a] <= dir_in[a] ? pos[a] + 1 : pos[a] - 1;
  // High-active sensors, pin inverted for normally closed contacts
  always_comb
    for (int a = 0; a < 3; a++)
    begin
      home_pin_out[a] = (pos[a] >= HOME_LO && pos[a] <= HOME_HI)
        ^ contact_nc_in[a][0];
      pos_limit_out[a] = (pos[a] >= LIMIT) ^ contact_nc_in[a][1];
      neg_limit_out[a] = (pos[a] <= -LIMIT) ^ contact_nc_in[a][2];
      index_out[a] = (pos[a] % INDEX_MOD) == 0;
    end
endmodule // ahs_motor_model

// *** testbench.sv ***
// Self-checking bench for the axis homing and status logic
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [3:0] mode;
    logic [15:0] pos;
    logic [2:0] nc;
    logic [7:0] lane0;
    logic [7:0] lane1;
  } ahs_row_t;
  // Mode, start position, contact type, status0 flags, second_status_byte bits
  localparam ahs_row_t ROWS [6] = '{
    '{ahs_pkg::HOME_MODE0, 16'h0000, 3'h0, 8'h40, 8'h04},
    '{ahs_pkg::HOME_MODE1, 16'h0000, 3'h7, 8'h40, 8'h04},
    '{ahs_pkg::HOME_MODE9, 16'h0000, 3'h0, 8'h40, 8'h00},
    '{ahs_pkg::HOME_MODE6, 16'h0000, 3'h0, 8'h60, 8'h02},
    '{ahs_pkg::HOME_MODE0, 16'h0046, 3'h0, 8'h40, 8'h04},
    '{ahs_pkg::HOME_MODE9, 16'h0032, 3'h0, 8'h40, 8'h00}};
  logic clk_sys_in, rst_n_in, cmd_wr_in, load;
  logic [1:0] cmd_axis_in;
  logic [7:0] cmd_data_in, rd_data_out, seen;
  logic [3:0] rd_lane_in;
  logic [15:0] load_pos;
  logic [2:0][15:0] start_speed_in, max_speed_in;
  logic [2:0] home_pin_in, positive_end_limit_in, negative_end_limit_in;
  logic [2:0] encoder_index_pulse_in, step_out, dir_out, home_done_out;
  logic [2:0][2:0] contact_nc_in;
  int err_total, checks;

  ahs_axis_home_status DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cmd_wr_in(cmd_wr_in), .cmd_axis_in(cmd_axis_in),
    .cmd_data_in(cmd_data_in), .rd_lane_in(rd_lane_in),
    .rd_data_out(rd_data_out), .start_speed_in(start_speed_in),
    .max_speed_in(max_speed_in), .home_pin_in(home_pin_in),
    .positive_end_limit_in(positive_end_limit_in),
    .negative_end_limit_in(negative_end_limit_in),
    .encoder_index_pulse_in(encoder_index_pulse_in),
    .contact_nc_in(contact_nc_in), .step_out(step_out),
    .dir_out(dir_out), .home_done_out(home_done_out));
  ahs_motor_model u_motor (.clk_sys_in(clk_sys_in), .load_in(load),
    .load_pos_in(load_pos), .step_in(step_out), .dir_in(dir_out),
    .contact_nc_in(contact_nc_in), .home_pin_out(home_pin_in),
    .pos_limit_out(positive_end_limit_in),
    .neg_limit_out(negative_end_limit_in),
    .index_out(encoder_index_pulse_in));

  // 50 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input string name, input logic [7:0] got,
                       input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic send(input logic [1:0] axis, input logic [7:0] data);
    @(posedge clk_sys_in);
    cmd_wr_in <= 1'b1;
    cmd_axis_in <= axis;
    cmd_data_in <= data;
    @(posedge clk_sys_in);
    cmd_wr_in <= 1'b0;
  endtask

  task automatic read(input logic [3:0] lane);
    @(posedge clk_sys_in);
    rd_lane_in <= lane;
    @(posedge clk_sys_in);
    #1;
    seen = rd_data_out;
  endtask

  task automatic place(input logic [15:0] p, input logic [2:0] nc);
    @(posedge clk_sys_in);
    load <= 1'b1;
    load_pos <= p;
    contact_nc_in <= {3{nc}};
    @(posedge clk_sys_in);
    load <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (home_done_out !== 3'h7 && n < 20000)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 20000)
      err_total++;
    repeat (6) @(posedge clk_sys_in);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk_sys_in);
    err_total++;
    print_verdict();
  end

  initial
  begin
    {rst_n_in, cmd_wr_in, load, cmd_axis_in, cmd_data_in} = '0;
    {rd_lane_in, load_pos, contact_nc_in} = '0;
    start_speed_in = {3{16'h0008}};
    max_speed_in = {3{16'h0002}};
    repeat (16) @(posedge clk_sys_in);
    check("dir", {5'h0, dir_out}, 8'h07);
    check("done", {5'h0, home_done_out}, 8'h00);
    rst_n_in <= 1'b1;
    $display("test reset done");
    for (int a = 0; a < 3; a++)
    begin
      send(2'(a), 8'hbf);
      send(2'(a), 8'hc0);
      send(2'(a), 8'hc1);
    end
    read(4'h6);
    check("std_status2", seen, 8'h00);
    for (int a = 0; a < 3; a++)
      send(2'(a), 8'he1);
    read(4'h6);
    check("ext_status2", seen, 8'h07);
    read(4'hd);
    check("lane13", seen, 8'h00);
    $display("test monitor done");
    for (int r = 0; r < 6; r++)
    begin
      place(ROWS[r].pos, ROWS[r].nc);
      for (int a = 0; a < 3; a++)
        send(2'(a), {4'h4, ROWS[r].mode});
      if (r == 0)
        send(2'h0, 8'h46);
      wait_done();
      for (int a = 0; a < 3; a++)
      begin
        read(4'(4 * a));
        check("status0", seen & 8'he0, ROWS[r].lane0);
        read(4'(4 * a + 1));
        check("second_status_byte", seen & 8'h07, ROWS[r].lane1);
        read(4'(4 * a + 2));
        check("status2", seen, {ROWS[r].mode, 4'h7});
      end
      $display("test home row %0d done", r);
    end
    send(2'h0, 8'h42);
    read(4'h0);
    check("bad_mode", seen & 8'he0, 8'h40);
    place(16'h0000, 3'h0);
    read(4'h0);
    check("index", seen & 8'h06, 8'h04);
    send(2'h0, 8'h40);
    repeat (40) @(posedge clk_sys_in);
    read(4'h0);
    check("running", seen & 8'he0, 8'h80);
    send(2'h0, 8'h00);
    read(4'h0);
    check("stopped", seen & 8'he0, 8'h00);
    send(2'h0, 8'hbe);
    read(4'h2);
    check("speed_lo", seen, 8'h08);
    read(4'h3);
    check("speed_hi", seen, 8'h00);
    $display("test refusal and stop done");
    print_verdict();
  end
endmodule // testbench
